/* File: hw/msc_regs.svh */
// register offsets, control fields and constants of the statistics readout
`ifndef MSC_REGS_SVH
`define MSC_REGS_SVH

// ==========================================================
// counter word locations (byte addresses)
`define MSC_RX_BYTES_LO 17'h00200
`define MSC_RX_BYTES_HI 17'h00204
`define MSC_TX_BYTES_LO 17'h00208
`define MSC_TX_BYTES_HI 17'h0020C
`define MSC_UNDERSIZE_LO 17'h00210
`define MSC_UNDERSIZE_HI 17'h00214

// ==========================================================
// control register
`define MSC_CTRL 17'h00368
`define MSC_CTRL_FREEZE 0
`define MSC_CTRL_CLEAR 1
`define MSC_CTRL_RST 1'h0

// ==========================================================
// sizes
`define MSC_CNT_WIDTH_DEF 64
`define MSC_NUM_CNT 3
`define MSC_MIN_FRAME 16'h0040
`define MSC_HOLD_RST 32'h00000000

`endif

/* File: hw/msc_pkg.sv */
// types shared by the statistics counter readout
package msc_pkg;

  // ==========================================================
  // bus and frame report types
  typedef logic [16:0] msc_addr_t;

  typedef struct packed {
    logic done;
    logic [15:0] len;
    logic fcs_ok;
  } msc_frame_s;

  typedef enum logic [1:0] {
    MSC_CNT_RX = 2'h0,
    MSC_CNT_TX = 2'h1,
    MSC_CNT_UND = 2'h2
  } msc_cnt_e;

  typedef struct packed {
    logic hit;
    logic upper;
    msc_cnt_e idx;
  } msc_dec_s;

endpackage

/* File: hw/msc_counter.sv */
// one statistics counter: adds a whole amount per update, wraps, never saturates
module msc_counter #(
  parameter int WIDTH = 64
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // update
  input wire logic clr,
  input wire logic inc_en,
  input wire logic [15:0] inc_amt,
  // state
  output logic [WIDTH-1:0] value
);

  logic [WIDTH-1:0] next_value;

  always_comb begin
    next_value = value;
    if (clr) begin
      next_value = '0;
    end else if (inc_en) begin
      // modulo add of the full frame amount in one step
      next_value = value + WIDTH'(inc_amt);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      value <= '0;
    end else begin
      value <= next_value;
    end
  end

endmodule // msc_counter

/* File: hw/msc_stat_readout.sv */
// statistics counter bank with snapshot-coherent 64-bit register readout
//
// Chosen here: the strobed register port.
`include "msc_regs.svh"

// Behaviour
// - counter width is a build parameter of 32 or 64, default 64
// - at 64 bits each counter shows as lower word then upper word
// - reading a lower word returns it and latches that counter's upper word
// - reading the matching upper word returns the latched value, not live bits
// - reading an upper word of another counter gives an error response
// - receive byte counter adds destination address through FCS bytes per frame
// - transmit byte counter adds destination address through FCS bytes per frame
// - undersize counter counts well-formed received frames under 64 bytes
module msc_stat_readout #(
  parameter int CNT_WIDTH = `MSC_CNT_WIDTH_DEF
) (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic SRST,
  // register port
  input wire msc_pkg::msc_addr_t REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA,
  output logic REG_ERR,
  // frame completion reports from the mac
  input wire msc_pkg::msc_frame_s RX_FRAME,
  input wire msc_pkg::msc_frame_s TX_FRAME
);
  import msc_pkg::*;

  // ==========================================================
  // address decode
  function automatic msc_dec_s decode(input msc_addr_t a);
    msc_dec_s d;
    d.hit = 1'b1;
    d.upper = 1'b0;
    d.idx = MSC_CNT_RX;
    if (a == `MSC_RX_BYTES_LO) begin
      d.idx = MSC_CNT_RX;
    end else if (a == `MSC_RX_BYTES_HI) begin
      d.upper = 1'b1;
      d.idx = MSC_CNT_RX;
    end else if (a == `MSC_TX_BYTES_LO) begin
      d.idx = MSC_CNT_TX;
    end else if (a == `MSC_TX_BYTES_HI) begin
      d.upper = 1'b1;
      d.idx = MSC_CNT_TX;
    end else if (a == `MSC_UNDERSIZE_LO) begin
      d.idx = MSC_CNT_UND;
    end else if (a == `MSC_UNDERSIZE_HI) begin
      d.upper = 1'b1;
      d.idx = MSC_CNT_UND;
    end else begin
      d.hit = 1'b0;
    end
    // upper words exist only for 64-bit counters
    if (CNT_WIDTH == 32 && d.upper) begin
      d.hit = 1'b0;
    end
    return d;
  endfunction

  // ==========================================================
  // word selection: bits 31:0 or 63:32 of a counter value
  function automatic logic [31:0] word_of(input logic [63:0] v, input logic upper);
    logic [31:0] w;
    w = v[31:0];
    if (upper) begin
      w = v[63:32];
    end
    return w;
  endfunction

  // ==========================================================
  // counters
  logic freeze;
  logic clr_pulse;
  logic inc_en [`MSC_NUM_CNT];
  logic [15:0] inc_amt [`MSC_NUM_CNT];
  logic [CNT_WIDTH-1:0] cnt [`MSC_NUM_CNT];
  logic [63:0] wide [`MSC_NUM_CNT];
  logic rx_undersize;
  logic [63:0] sel_val;

  // ==========================================================
  // frame reports into counter increments
  // well formed but short: good fcs, below the minimum frame size
  assign rx_undersize = RX_FRAME.done && RX_FRAME.fcs_ok &&
                        (RX_FRAME.len < `MSC_MIN_FRAME);

  always_comb begin
    inc_en[MSC_CNT_RX] = RX_FRAME.done && !freeze;
    inc_amt[MSC_CNT_RX] = RX_FRAME.len;
    inc_en[MSC_CNT_TX] = TX_FRAME.done && !freeze;
    inc_amt[MSC_CNT_TX] = TX_FRAME.len;
    inc_en[MSC_CNT_UND] = rx_undersize && !freeze;
    inc_amt[MSC_CNT_UND] = 16'h0001;
  end

  // ==========================================================
  // counter instances
  // a clear in the same edge as a frame report drops that frame
  for (genvar i = 0; i < `MSC_NUM_CNT; i++) begin : g_cnt
    msc_counter #(
      .WIDTH(CNT_WIDTH)
    ) u_cnt (
      .clk(REF_CLK),
      .srst(SRST),
      .clr(clr_pulse),
      .inc_en(inc_en[i]),
      .inc_amt(inc_amt[i]),
      .value(cnt[i])
    );
    // narrow counters read with a zero upper half
    assign wide[i] = 64'(cnt[i]);
  end

  // ==========================================================
  // register access state
  msc_dec_s rd_dec;
  logic ctrl_wr;
  logic ctrl_rd;
  logic lo_rd;
  logic hi_rd;
  logic hi_match;
  logic [31:0] hold;
  msc_cnt_e hold_idx;
  logic hold_vld;
  logic [31:0] next_hold;
  msc_cnt_e next_hold_idx;
  logic next_hold_vld;
  logic next_freeze;
  logic next_clr_pulse;
  logic [31:0] next_rdata;
  logic next_err;

  // ==========================================================
  // access decode
  assign rd_dec = decode(REG_ADDR);
  assign sel_val = wide[rd_dec.idx];
  assign ctrl_wr = REG_WR && (REG_ADDR == `MSC_CTRL);
  assign ctrl_rd = REG_RD && (REG_ADDR == `MSC_CTRL);
  assign lo_rd = REG_RD && rd_dec.hit && !rd_dec.upper;
  assign hi_rd = REG_RD && rd_dec.hit && rd_dec.upper;
  // an upper word answers only for the counter whose lower word was read last
  assign hi_match = hold_vld && (hold_idx == rd_dec.idx);

  // ==========================================================
  // control register: freeze level and one-cycle clear
  always_comb begin
    next_freeze = freeze;
    next_clr_pulse = 1'b0;
    if (ctrl_wr) begin
      next_freeze = REG_WDATA[`MSC_CTRL_FREEZE];
      // clear is a strobe: it never stays set, so it reads back as zero
      next_clr_pulse = REG_WDATA[`MSC_CTRL_CLEAR];
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      freeze <= `MSC_CTRL_RST;
      clr_pulse <= 1'b0;
    end else begin
      freeze <= next_freeze;
      clr_pulse <= next_clr_pulse;
    end
  end

  // ==========================================================
  // snapshot of the upper word, taken with every lower-word read
  always_comb begin
    next_hold = hold;
    next_hold_idx = hold_idx;
    next_hold_vld = hold_vld;
    if (lo_rd) begin
      // both words come from one edge, so a carry between the two reads cannot tear them
      next_hold = word_of(sel_val, 1'b1);
      next_hold_idx = rd_dec.idx;
      next_hold_vld = 1'b1;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      hold <= `MSC_HOLD_RST;
      hold_idx <= MSC_CNT_RX;
      hold_vld <= 1'b0;
    end else begin
      hold <= next_hold;
      hold_idx <= next_hold_idx;
      hold_vld <= next_hold_vld;
    end
  end

  // ==========================================================
  // read answer: stands one cycle after the strobe, zero otherwise
  always_comb begin
    next_rdata = 32'h00000000;
    next_err = 1'b0;
    if (ctrl_rd) begin
      next_rdata[`MSC_CTRL_FREEZE] = freeze;
    end else if (lo_rd) begin
      next_rdata = word_of(sel_val, 1'b0);
    end else if (hi_rd) begin
      if (hi_match) begin
        next_rdata = hold;
      end else begin
        next_err = 1'b1;
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      REG_RDATA <= 32'h00000000;
      REG_ERR <= 1'b0;
    end else begin
      REG_RDATA <= next_rdata;
      REG_ERR <= next_err;
    end
  end

endmodule // msc_stat_readout

/* File: bench/msc_stat_readout_asserts.sv */
// port assertions of the statistics readout
module msc_stat_readout_asserts #(parameter int CNT_WIDTH = 64) (
  // clock, reset, register port
  input wire logic REF_CLK,
  input wire logic SRST,
  input wire msc_pkg::msc_addr_t REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [31:0] REG_RDATA,
  input wire logic REG_ERR,
  // frame reports
  input wire msc_pkg::msc_frame_s RX_FRAME,
  input wire msc_pkg::msc_frame_s TX_FRAME
);
  import msc_pkg::*;
  // ====
  // last lower word read, 0 when none
  logic [16:0] last_lo;
  logic [16:0] next_last_lo;
  wire rd_lo = REG_RD && REG_ADDR inside {17'h200, 17'h208, 17'h210};
  wire rd_hi = REG_RD && REG_ADDR inside {17'h204, 17'h20C, 17'h214};
  wire rd_rx = REG_RD && REG_ADDR == 17'h200;
  wire rd_tx = REG_RD && REG_ADDR == 17'h208;
  always_comb next_last_lo = rd_lo ? REG_ADDR : last_lo;
  always_ff @(posedge REF_CLK) last_lo <= SRST ? 17'h0 : next_last_lo;
  // freeze level as written over the control register
  logic frz;
  logic next_frz;
  always_comb next_frz = (REG_WR && REG_ADDR == 17'h368) ? REG_WDATA[0] : frz;
  always_ff @(posedge REF_CLK) frz <= SRST ? 1'h0 : next_frz;
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SRST);
  property p_quiet; !$past(REG_RD) |-> REG_RDATA == 32'h0 && !REG_ERR; endproperty
  a_quiet: assert property (p_quiet) else $error("stray answer");
  property p_err; REG_ERR |-> $past(rd_hi) && REG_RDATA == 32'h0; endproperty
  a_err: assert property (p_err) else $error("stray error");
  property p_miss; CNT_WIDTH == 64 && rd_hi && last_lo != REG_ADDR - 17'h4 |=> REG_ERR; endproperty
  a_miss: assert property (p_miss) else $error("missing error");
  property p_lo; rd_lo |=> !REG_ERR; endproperty
  a_lo: assert property (p_lo) else $error("lower word error");
  property p_match; rd_hi && last_lo == REG_ADDR - 17'h4 |=> !REG_ERR; endproperty
  a_match: assert property (p_match) else $error("matched upper error");
  property p_hold; rd_hi ##1 rd_hi && $stable(REG_ADDR) |=> $stable(REG_RDATA); endproperty
  a_hold: assert property (p_hold) else $error("upper word moved");
  property p_rx; rd_rx && RX_FRAME.done && !frz && !$past(REG_WR) ##1 rd_rx
    |=> REG_RDATA == $past(REG_RDATA) + 32'($past(RX_FRAME.len, 2)); endproperty
  a_rx: assert property (p_rx) else $error("rx bytes");
  property p_tx; rd_tx && TX_FRAME.done && !frz && !$past(REG_WR) ##1 rd_tx
    |=> REG_RDATA == $past(REG_RDATA) + 32'($past(TX_FRAME.len, 2)); endproperty
  a_tx: assert property (p_tx) else $error("tx bytes");
  property p_frz; rd_rx && RX_FRAME.done && frz && !$past(REG_WR) ##1 rd_rx
    |=> REG_RDATA == $past(REG_RDATA); endproperty
  a_frz: assert property (p_frz) else $error("frozen rx bytes moved");
endmodule // msc_stat_readout_asserts
bind msc_stat_readout msc_stat_readout_asserts #(.CNT_WIDTH(CNT_WIDTH)) msc_stat_readout_asserts_i (
  .REF_CLK, .SRST, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA, .REG_ERR,
  .RX_FRAME, .TX_FRAME);

/* File: bench/test_msc_stat_readout.sv */
// directed bench of the statistics readout
module test_msc_stat_readout;
  timeunit 1ns;
  timeprecision 1ns;
  import msc_pkg::*;
  `define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin n_errors++; \
    $display("BAD %s exp %h got %h", n, e, s); end end
  logic REF_CLK = 1'h0;
  logic SRST = 1'h1;
  logic REG_WR = 1'h0;
  logic REG_RD = 1'h0;
  logic REG_ERR;
  logic [31:0] REG_WDATA = '0;
  logic [31:0] REG_RDATA;
  msc_addr_t REG_ADDR = '0;
  msc_frame_s RX_FRAME = '0;
  msc_frame_s TX_FRAME = '0;
  int n_errors = 0;
  int n_tests = 0;
  msc_stat_readout msc_stat_readout_i (.REF_CLK, .SRST, .REG_ADDR, .REG_WDATA, .REG_WR,
    .REG_RD, .REG_RDATA, .REG_ERR, .RX_FRAME, .TX_FRAME);
  function automatic msc_frame_s fr(logic [15:0] n, logic ok);
    return {1'h1, n, ok};
  endfunction
  // two back-to-back reads, frames offered in the first cycle
  task automatic rd2(msc_addr_t a, msc_addr_t b, msc_frame_s rx, msc_frame_s tx,
    logic [31:0] da, logic [31:0] db, logic eb);
    @(posedge REF_CLK);
    REG_RD <= 1'h1;
    REG_ADDR <= a;
    RX_FRAME <= rx;
    TX_FRAME <= tx;
    @(posedge REF_CLK);
    REG_ADDR <= b;
    RX_FRAME <= '0;
    TX_FRAME <= '0;
    #1 `CHK("first", da, REG_RDATA)
    @(posedge REF_CLK);
    REG_RD <= 1'h0;
    #1 `CHK("second", db, REG_RDATA)
    `CHK("error", eb, REG_ERR)
  endtask
  // one-cycle write strobe
  task automatic wr(msc_addr_t a, logic [31:0] d);
    @(posedge REF_CLK);
    REG_WR <= 1'h1;
    REG_ADDR <= a;
    REG_WDATA <= d;
    @(posedge REF_CLK);
    REG_WR <= 1'h0;
  endtask
  task automatic finish_test();
    $display("errors %0d checks %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    forever #5 REF_CLK = ~REF_CLK;
  end
  initial begin
    #700000;
    n_errors++;
    finish_test();
  end
  initial begin
    repeat (2) @(posedge REF_CLK);
    SRST <= 1'h0;
    rd2(17'h204, 17'h204, '0, '0, 32'h0, 32'h0, 1'h1);
    rd2(17'h200, 17'h200, fr(16'h3C, 1'h1), '0, 32'h0, 32'h3C, 1'h0);
    rd2(17'h208, 17'h208, fr(16'h28, 1'h0), fr(16'h5DC, 1'h1), 32'h0, 32'h5DC, 1'h0);
    rd2(17'h210, 17'h214, fr(16'h40, 1'h1), '0, 32'h1, 32'h0, 1'h0);
    // carry into the upper word: 65538 frames of 65535 bytes
    @(posedge REF_CLK);
    TX_FRAME <= fr(16'hFFFF, 1'h1);
    repeat (65538) @(posedge REF_CLK);
    TX_FRAME <= '0;
    rd2(17'h200, 17'h204, '0, '0, 32'hA4, 32'h0, 1'h0);
    rd2(17'h208, 17'h20C, '0, '0, 32'h105DA, 32'h1, 1'h0);
    rd2(17'h218, 17'h204, '0, '0, 32'h0, 32'h0, 1'h1);
    rd2(17'h218, 17'h20C, '0, '0, 32'h0, 32'h1, 1'h0);
    @(posedge REF_CLK);
    REG_WR <= 1'h1;
    REG_ADDR <= 17'h368;
    REG_WDATA <= 32'h2;
    @(posedge REF_CLK);
    REG_WR <= 1'h0;
    rd2(17'h208, 17'h20C, '0, '0, 32'h0, 32'h0, 1'h0);
    // frozen counters drop frame reports, freeze reads back
    wr(17'h368, 32'h1);
    rd2(17'h200, 17'h200, fr(16'h40, 1'h1), fr(16'h40, 1'h1), 32'h0, 32'h0, 1'h0);
    rd2(17'h208, 17'h368, '0, '0, 32'h0, 32'h1, 1'h0);
    wr(17'h368, 32'h0);
    rd2(17'h368, 17'h200, fr(16'h14, 1'h1), '0, 32'h0, 32'h14, 1'h0);
    // reset in mid-run drops the snapshot and zeroes the counters
    @(posedge REF_CLK);
    SRST <= 1'h1;
    repeat (2) @(posedge REF_CLK);
    SRST <= 1'h0;
    rd2(17'h218, 17'h20C, '0, '0, 32'h0, 32'h0, 1'h1);
    rd2(17'h200, 17'h204, '0, '0, 32'h0, 32'h0, 1'h0);
    finish_test();
  end
endmodule // test_msc_stat_readout
